// >>> hw/pha_params.svh
`ifndef PHA_PARAMS_SVH
`define PHA_PARAMS_SVH

// ----------------------------------------
// Register select codes
// ----------------------------------------
`define PHA_RS_PTR_WR 3'h0
`define PHA_RS_PAL_DATA 3'h1
`define PHA_RS_READ_MASK 3'h2
`define PHA_RS_PTR_RD 3'h3
`define PHA_RS_PTR_OVL_WR 3'h4
`define PHA_RS_OVL_DATA 3'h5
`define PHA_RS_CTRL 3'h6
`define PHA_RS_PTR_OVL_RD 3'h7

// ----------------------------------------
// Control register locations
// ----------------------------------------
`define PHA_WIN_LAST 8'h7F
`define PHA_CMD0_ADDR 8'h82
`define PHA_CMD1_ADDR 8'h83
`define PHA_FLOOD_LO_ADDR 8'h84
`define PHA_FLOOD_HI_ADDR 8'h85

// ----------------------------------------
// Field positions, reset values, blue phase code and buffer depth
// ----------------------------------------
`define PHA_SEG_LSB 4
`define PHA_EIGHT_BIT_POS 1
`define PHA_CMD0_RESET 8'h00
`define PHA_CMD1_RESET 8'h00
`define PHA_FLOOD_RESET 8'h00
`define PHA_PTR_RESET 8'h00
`define PHA_PHASE_BLUE 2'h2
`define PHA_FIFO_DEPTH 8

`endif

// >>> hw/pha_pkg.sv
package pha_pkg;

    typedef struct packed {
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
    } pha_rgb_t;

    typedef struct packed {
        logic is_overlay;
        logic [9:0] addr;
        pha_rgb_t rgb;
    } pha_entry_t;

    typedef struct packed {
        logic rd_n;
        logic wr_n;
        logic native;
        logic [2:0] rs;
        logic [7:0] data;
    } pha_pins_t;

    // Gray order along write -> read -> overlay read -> overlay write
    typedef enum logic [1:0] {
        PHA_MODE_PAL_WR = 2'b00,
        PHA_MODE_PAL_RD = 2'b01,
        PHA_MODE_OVL_RD = 2'b11,
        PHA_MODE_OVL_WR = 2'b10
    } pha_mode_t;

endpackage

// >>> hw/pha_host_port.sv
// Behaviour
// - 8-bit pointer addresses palette, overlay, control
// - Segment field picks one of four segments
// - Blue write stores joined word at segment+pointer
// - Pointer increments after every blue cycle
// - Read-mode pointer load prefetches then increments
// - Blue read prefetches next word, increments again
// - Overlay blue write stores word, increments pointer
// - Overlay read load and blue read prefetch
// - Control write is one byte, then increment
// - Control read is one byte, then increment
// - Palette pointer wraps to zero after top
// - Overlay entry uses low four pointer bits
// - Control pointer wraps to zero after top
// - Reserved control writes ignored, reads return zero
// - Storage transfers synchronised, between host cycles
// - Output colour held during storage transfers
// - Control accesses leave video output untouched
// - Hidden phase counts modulo three, cleared on load
// - Pointer read changes neither pointer nor mode
// - Legacy select low disables control byte, 6-bit
// - 6-bit uses lines 0-5, low converter bits zero
// - Codes 000,011,001: write load, read load, palette
// - Codes 100,111,101,110: overlay loads, overlay, control
// - Segment codes 0000-0011 extend pointer to ten bits
`timescale 1ns/1ps
`default_nettype none
`include "pha_params.svh"

// ----------------------------------------
// Write buffer
// ----------------------------------------
module pha_fifo #(
    parameter int WIDTH = 35,
    parameter int DEPTH = 8
) (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic [WIDTH-1:0] in_data_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    output logic [WIDTH-1:0] out_data_out,
    output logic out_valid_out,
    input wire logic out_ready_in
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic push;
    logic pop;

    assign in_ready_out = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
    assign out_valid_out = wr_ptr != rd_ptr;
    assign out_data_out = mem[rd_ptr[AW-1:0]];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    always_ff @(posedge clk_sys_in) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data_in;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + (AW+1)'(1);
            end
            if (pop) begin
                rd_ptr <= rd_ptr + (AW+1)'(1);
            end
        end
    end
endmodule

// ----------------------------------------
// Host access port
// ----------------------------------------
module pha_host_port #(
    parameter int FIFO_DEPTH = `PHA_FIFO_DEPTH
) (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic host_rd_n_in,
    input wire logic host_wr_n_in,
    input wire logic [2:0] register_select_in,
    input wire logic [7:0] host_data_lines_in,
    output logic [7:0] host_data_lines_out,
    output logic host_data_lines_oe_out,
    input wire logic native_mode_in,
    input wire logic [9:0] pixel_addr_in,
    output pha_pkg::pha_rgb_t color_out
);
    import pha_pkg::*;

    pha_pins_t pins_meta;
    pha_pins_t pins;
    logic rd_n_q;
    logic wr_n_q;
    logic rd_fall;
    logic rd_rise;
    logic wr_rise;
    logic wpend;
    logic [2:0] wpend_rs;
    logic [7:0] wpend_data;
    logic [2:0] rd_rs;
    logic [7:0] palette_pointer;
    logic [1:0] color_phase_counter;
    pha_mode_t mode;
    pha_rgb_t hold;
    logic [7:0] hold_bytes [3];
    logic fetch_pend;
    logic fetch_ovl;
    logic [9:0] fetch_addr;
    logic [23:0] palette_ram [1024];
    logic [23:0] overlay_ram [16];
    logic [7:0] window_regs [128];
    logic [7:0] cmd0;
    logic [7:0] cmd1;
    logic [7:0] flood_lo;
    logic [7:0] flood_hi;
    logic native;
    logic eight_bit;
    logic [1:0] segment;
    logic [7:0] wbyte;
    logic w_go;
    logic w_col;
    logic w_load;
    logic w_ctrl;
    logic w_blue;
    logic r_col;
    logic r_blue;
    logic host_idle;
    logic fetch_fire;
    logic drain_fire;
    logic transfer_busy;
    logic [7:0] ctrl_rd;
    logic [7:0] next_rdata;
    pha_rgb_t fetch_word;
    pha_entry_t fifo_in;
    pha_entry_t fifo_out;
    logic fifo_in_ready;
    logic fifo_out_valid;

    // ----------------------------------------
    // Pin synchronisers and strobe edges
    // ----------------------------------------
    // Data and select travel with the strobes so all arrive together
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            pins_meta <= '{rd_n: 1'b1, wr_n: 1'b1, native: 1'b1, rs: 3'h0, data: 8'h00};
            pins <= '{rd_n: 1'b1, wr_n: 1'b1, native: 1'b1, rs: 3'h0, data: 8'h00};
            rd_n_q <= 1'b1;
            wr_n_q <= 1'b1;
        end else begin
            pins_meta <= '{rd_n: host_rd_n_in, wr_n: host_wr_n_in, native: native_mode_in,
                           rs: register_select_in, data: host_data_lines_in};
            pins <= pins_meta;
            rd_n_q <= pins.rd_n;
            wr_n_q <= pins.wr_n;
        end
    end

    assign rd_fall = rd_n_q && !pins.rd_n;
    assign rd_rise = !rd_n_q && pins.rd_n;
    assign wr_rise = !wr_n_q && pins.wr_n;
    assign native = pins.native;
    assign eight_bit = native && cmd0[`PHA_EIGHT_BIT_POS];
    assign segment = native ? cmd0[`PHA_SEG_LSB +: 2] : 2'h0;

    // ----------------------------------------
    // Event decode
    // ----------------------------------------
    assign w_col = (wpend_rs == `PHA_RS_PAL_DATA) || (wpend_rs == `PHA_RS_OVL_DATA);
    assign w_load = (wpend_rs == `PHA_RS_PTR_WR) || (wpend_rs == `PHA_RS_PTR_RD) ||
                    (wpend_rs == `PHA_RS_PTR_OVL_WR) || (wpend_rs == `PHA_RS_PTR_OVL_RD);
    assign w_ctrl = wpend_rs == `PHA_RS_CTRL;
    assign w_blue = w_col && (color_phase_counter == `PHA_PHASE_BLUE);
    // A full buffer stalls the blue write; the drain needs host_idle, which waits for wpend to clear
    assign w_go = wpend && !(w_blue && !fifo_in_ready);
    assign r_col = (rd_rs == `PHA_RS_PAL_DATA) || (rd_rs == `PHA_RS_OVL_DATA);
    assign r_blue = rd_rise && r_col && (color_phase_counter == `PHA_PHASE_BLUE);
    // 6-bit data sits in the top of the byte so converter LSBs stay zero
    assign wbyte = eight_bit ? wpend_data : {wpend_data[5:0], 2'b00};

    // Transfers only run while no host strobe is active
    assign host_idle = pins.rd_n && pins.wr_n && rd_n_q && wr_n_q && !wpend;
    assign drain_fire = host_idle && fifo_out_valid;
    // Fetch waits for the buffer to empty so it sees every prior write
    assign fetch_fire = host_idle && fetch_pend && !fifo_out_valid;
    assign transfer_busy = drain_fire || fetch_fire;
    assign fetch_word = fetch_ovl ? overlay_ram[fetch_addr[3:0]] : palette_ram[fetch_addr];

    // ----------------------------------------
    // Pending host write
    // ----------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            wpend <= 1'b0;
            wpend_rs <= 3'h0;
            wpend_data <= 8'h00;
        end else if (wr_rise) begin
            wpend <= 1'b1;
            wpend_rs <= pins.rs;
            wpend_data <= pins.data;
        end else if (w_go) begin
            wpend <= 1'b0;
        end
    end

    // ----------------------------------------
    // Pointer, phase and mode
    // ----------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            palette_pointer <= `PHA_PTR_RESET;
            color_phase_counter <= 2'h0;
            mode <= PHA_MODE_PAL_WR;
            fetch_pend <= 1'b0;
            fetch_ovl <= 1'b0;
            fetch_addr <= 10'h000;
        end else begin
            if (fetch_fire) begin
                fetch_pend <= 1'b0;
            end
            if (w_go && w_load) begin
                color_phase_counter <= 2'h0;
                case (wpend_rs)
                    `PHA_RS_PTR_RD: begin
                        mode <= PHA_MODE_PAL_RD;
                        fetch_pend <= 1'b1;
                        fetch_ovl <= 1'b0;
                        fetch_addr <= {segment, wpend_data};
                        palette_pointer <= wpend_data + 8'h01;
                    end
                    `PHA_RS_PTR_OVL_RD: begin
                        mode <= PHA_MODE_OVL_RD;
                        fetch_pend <= 1'b1;
                        fetch_ovl <= 1'b1;
                        fetch_addr <= {6'h00, wpend_data[3:0]};
                        palette_pointer <= wpend_data + 8'h01;
                    end
                    `PHA_RS_PTR_OVL_WR: begin
                        mode <= PHA_MODE_OVL_WR;
                        palette_pointer <= wpend_data;
                    end
                    default: begin
                        mode <= PHA_MODE_PAL_WR;
                        palette_pointer <= wpend_data;
                    end
                endcase
            end else if (w_go && w_col) begin
                color_phase_counter <= w_blue ? 2'h0 : color_phase_counter + 2'h1;
                if (w_blue) begin
                    palette_pointer <= palette_pointer + 8'h01;
                end
            end else if (w_go && w_ctrl) begin
                palette_pointer <= palette_pointer + 8'h01;
            end else if (rd_rise && r_col) begin
                color_phase_counter <= r_blue ? 2'h0 : color_phase_counter + 2'h1;
                if (r_blue) begin
                    fetch_pend <= 1'b1;
                    fetch_ovl <= rd_rs[2];
                    fetch_addr <= rd_rs[2] ? {6'h00, palette_pointer[3:0]} :
                                             {segment, palette_pointer};
                    palette_pointer <= palette_pointer + 8'h01;
                end
            end else if (rd_rise && rd_rs == `PHA_RS_CTRL) begin
                palette_pointer <= palette_pointer + 8'h01;
            end
            // Pointer reads fall through untouched, mode included
        end
    end

    // ----------------------------------------
    // Colour holding registers
    // ----------------------------------------
    assign hold = '{red: hold_bytes[0], green: hold_bytes[1], blue: hold_bytes[2]};

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            hold_bytes <= '{8'h00, 8'h00, 8'h00};
        end else if (w_go && w_col && !w_blue) begin
            hold_bytes[color_phase_counter] <= wbyte;
        end else if (fetch_fire) begin
            hold_bytes <= '{fetch_word.red, fetch_word.green, fetch_word.blue};
        end
    end

    // ----------------------------------------
    // Write buffer and lookup storage
    // ----------------------------------------
    assign fifo_in.is_overlay = wpend_rs[2];
    assign fifo_in.addr = wpend_rs[2] ? {6'h00, palette_pointer[3:0]} :
                                        {segment, palette_pointer};
    assign fifo_in.rgb = '{red: hold_bytes[0], green: hold_bytes[1], blue: wbyte};

    pha_fifo #(
        .WIDTH($bits(pha_entry_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_in(clk_sys_in),
        .resetn_in(resetn_in),
        .in_data_in(fifo_in),
        .in_valid_in(wpend && w_blue),
        .in_ready_out(fifo_in_ready),
        .out_data_out(fifo_out),
        .out_valid_out(fifo_out_valid),
        .out_ready_in(host_idle)
    );

    always_ff @(posedge clk_sys_in) begin
        if (drain_fire && !fifo_out.is_overlay) begin
            palette_ram[fifo_out.addr] <= fifo_out.rgb;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (drain_fire && fifo_out.is_overlay) begin
            overlay_ram[fifo_out.addr[3:0]] <= fifo_out.rgb;
        end
    end

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            cmd0 <= `PHA_CMD0_RESET;
            cmd1 <= `PHA_CMD1_RESET;
            flood_lo <= `PHA_FLOOD_RESET;
            flood_hi <= `PHA_FLOOD_RESET;
            for (int i = 0; i < 128; i++) begin
                window_regs[i] <= 8'h00;
            end
        end else if (w_go && w_ctrl) begin
            if (palette_pointer <= `PHA_WIN_LAST) begin
                window_regs[palette_pointer[6:0]] <= wpend_data;
            end
            case (palette_pointer)
                `PHA_CMD0_ADDR: cmd0 <= wpend_data;
                `PHA_CMD1_ADDR: cmd1 <= wpend_data;
                `PHA_FLOOD_LO_ADDR: flood_lo <= wpend_data;
                `PHA_FLOOD_HI_ADDR: flood_hi <= wpend_data;
                default: ;
            endcase
        end
    end

    always_comb begin
        ctrl_rd = 8'h00; // Reserved locations read as zero
        if (palette_pointer <= `PHA_WIN_LAST) begin
            ctrl_rd = window_regs[palette_pointer[6:0]];
        end
        case (palette_pointer)
            `PHA_CMD0_ADDR: ctrl_rd = cmd0;
            `PHA_CMD1_ADDR: ctrl_rd = cmd1;
            `PHA_FLOOD_LO_ADDR: ctrl_rd = flood_lo;
            `PHA_FLOOD_HI_ADDR: ctrl_rd = flood_hi;
            default: ;
        endcase
    end

    // ----------------------------------------
    // Host read data
    // ----------------------------------------
    always_comb begin
        next_rdata = 8'h00;
        case (pins.rs)
            `PHA_RS_PTR_WR, `PHA_RS_PTR_RD, `PHA_RS_PTR_OVL_WR, `PHA_RS_PTR_OVL_RD: begin
                next_rdata = palette_pointer;
            end
            `PHA_RS_PAL_DATA, `PHA_RS_OVL_DATA: begin
                next_rdata = eight_bit ? hold_bytes[color_phase_counter] :
                             {2'b00, hold_bytes[color_phase_counter][7:2]};
            end
            `PHA_RS_CTRL: next_rdata = ctrl_rd;
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            host_data_lines_out <= 8'h00;
            host_data_lines_oe_out <= 1'b0;
            rd_rs <= 3'h0;
        end else if (rd_fall) begin
            host_data_lines_out <= next_rdata;
            host_data_lines_oe_out <= 1'b1;
            rd_rs <= pins.rs;
        end else if (rd_rise) begin
            host_data_lines_oe_out <= 1'b0;
        end
    end

    // ----------------------------------------
    // Display colour
    // ----------------------------------------
    // Storage port busy means the colour would be torn, so keep the last
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            color_out <= '0;
        end else if (!transfer_busy) begin
            color_out <= palette_ram[pixel_addr_in];
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!resetn_in);

    a_phase_mod_three: assert property (color_phase_counter != 2'h3)
        else $error("phase counter left modulo three");
    a_load_clears_phase: assert property (w_go && w_load |=> color_phase_counter == 2'h0)
        else $error("pointer load did not clear phase");
    a_ptr_read_keeps: assert property (rd_rise && !r_col && rd_rs != `PHA_RS_CTRL
        |=> $stable(palette_pointer) && $stable(mode) && $stable(color_phase_counter))
        else $error("pointer read disturbed state");
    a_blue_write_incr: assert property (w_go && w_blue
        |=> palette_pointer == $past(palette_pointer) + 8'h01 && color_phase_counter == 2'h0)
        else $error("blue write did not step pointer");
    a_ctrl_write_incr: assert property (w_go && w_ctrl
        |=> palette_pointer == $past(palette_pointer) + 8'h01)
        else $error("control write did not step pointer");
    a_blue_read_fetch: assert property (r_blue
        |=> fetch_pend && fetch_addr[7:0] == (fetch_ovl ? {4'h0, $past(palette_pointer[3:0])}
                                                        : $past(palette_pointer)))
        else $error("blue read did not queue fetch");
    a_fetch_fills_hold: assert property (fetch_fire |=> hold == $past(fetch_word))
        else $error("fetch did not load holding registers");
    a_overlay_index: assert property (wpend && w_blue && wpend_rs[2]
        |-> fifo_in.addr[9:4] == 6'h00)
        else $error("overlay index uses upper pointer bits");
    // Only a transfer that would have changed the shown colour is of interest
    a_color_hold: assert property (transfer_busy && palette_ram[pixel_addr_in] != color_out
        |=> $stable(color_out))
        else $error("output colour changed during transfer");
    a_reserved_ignored: assert property (w_go && w_ctrl && palette_pointer > `PHA_FLOOD_HI_ADDR
        |=> $stable(cmd0) && $stable(cmd1) && $stable(flood_lo) && $stable(flood_hi))
        else $error("reserved write changed a register");
    a_legacy_six_bit: assert property (rd_fall && !native && (pins.rs == `PHA_RS_PAL_DATA)
        |=> host_data_lines_out[7:6] == 2'b00 && host_data_lines_oe_out)
        else $error("legacy colour read drove upper lines");
    a_legacy_segment: assert property (!native |-> segment == 2'h0)
        else $error("legacy mode used nonzero segment");
endmodule

`default_nettype wire

// >>> tb/pha_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Host bus model
// ----------------------------------------
module pha_host_model (
    input wire logic clk_in,
    output logic rd_n_out,
    output logic wr_n_out,
    output logic [2:0] rs_out,
    output logic [7:0] data_out,
    input wire logic [7:0] data_in,
    input wire logic oe_in
);
    // Strobes idle high so reset release sees no edge
    initial begin
        rd_n_out = 1'b1;
        wr_n_out = 1'b1;
        rs_out = 3'h0;
        data_out = 8'h00;
    end

    // Eight clocks low and high, above the six-clock floor
    task automatic wr(input logic [2:0] rs, input logic [7:0] d);
        @(negedge clk_in);
        rs_out = rs;
        data_out = d;
        wr_n_out = 1'b0;
        repeat (8) @(negedge clk_in);
        wr_n_out = 1'b1;
        repeat (8) @(negedge clk_in);
        // Released lines never keep the old byte
        data_out = ~d;
    endtask

    task automatic rd(input logic [2:0] rs, output logic [7:0] q);
        @(negedge clk_in);
        rs_out = rs;
        rd_n_out = 1'b0;
        repeat (8) @(negedge clk_in);
        q = (oe_in === 1'b1) ? data_in : 8'hXX;
        rd_n_out = 1'b1;
        // Idle gap leaves room for the prefetch
        repeat (8) @(negedge clk_in);
    endtask
endmodule

`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import pha_pkg::*;
    logic clk_sys_in;
    logic resetn_in;
    logic rd_n;
    logic wr_n;
    logic oe;
    logic native;
    logic [2:0] rs;
    logic [7:0] hd;
    logic [7:0] din;
    logic [7:0] dout;
    logic [7:0] q;
    logic [9:0] pix;
    pha_rgb_t color;
    int num_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    localparam logic [23:0] ROWS [5] = '{24'h00A5A5, 24'h7F3C3C, 24'h805500,
                                         24'h841212, 24'hFF7700};
    // One word past the read range is written so every prefetch meets known data
    localparam logic [7:0] PAL [9] = '{8'hA1, 8'hB2, 8'hC3, 8'hD4, 8'hE5, 8'hF6,
                                       8'h17, 8'h28, 8'h39};
    localparam logic [7:0] OVL [6] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66};
    localparam logic [7:0] LEG [6] = '{8'hFF, 8'h81, 8'h42, 8'h3F, 8'hC0, 8'h15};

    // Wire level from both drivers
    assign din = oe ? dout : hd;

    pha_host_port pha_host_port_i (
        .clk_sys_in(clk_sys_in),
        .resetn_in(resetn_in),
        .host_rd_n_in(rd_n),
        .host_wr_n_in(wr_n),
        .register_select_in(rs),
        .host_data_lines_in(din),
        .host_data_lines_out(dout),
        .host_data_lines_oe_out(oe),
        .native_mode_in(native),
        .pixel_addr_in(pix),
        .color_out(color)
    );

    pha_host_model pha_host_model_i (
        .clk_in(clk_sys_in),
        .rd_n_out(rd_n),
        .wr_n_out(wr_n),
        .rs_out(rs),
        .data_out(hd),
        .data_in(dout),
        .oe_in(oe)
    );

    // ----------------------------------------
    // Clock, timeout, reporting
    // ----------------------------------------
    initial begin
        clk_sys_in = 1'b0;
        forever #50 clk_sys_in = ~clk_sys_in;
    end

    // About 235 host cycles of 17 clocks each
    always @(posedge clk_sys_in) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            num_errors++;
            end_sim();
        end
    end

    task automatic end_sim();
        if (num_errors == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic w(input logic [2:0] r, input logic [7:0] d);
        pha_host_model_i.wr(r, d);
    endtask

    task automatic rc(input logic [2:0] r, input logic [7:0] e, input string n);
        pha_host_model_i.rd(r, q);
        chk(n, {16'h0000, q}, {16'h0000, e});
    endtask

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        resetn_in = 1'b0;
        native = 1'b1;
        pix = 10'h000;
        repeat (12) @(negedge clk_sys_in);
        chk("reset oe dout", {15'h0000, oe, dout}, 24'h000000);
        chk("reset color", color, 24'h000000);
        resetn_in = 1'b1;
        rc(3'h0, 8'h00, "pointer reset");
        foreach (ROWS[i]) begin
            w(3'h0, ROWS[i][23:16]);
            w(3'h6, ROWS[i][15:8]);
            rc(3'h3, ROWS[i][23:16] + 8'h01, "ctl wr pointer");
            w(3'h0, ROWS[i][23:16]);
            rc(3'h6, ROWS[i][7:0], "ctl data");
            rc(3'h0, ROWS[i][23:16] + 8'h01, "ctl rd pointer");
        end
        // Segment one, full width
        w(3'h0, 8'h82);
        w(3'h6, 8'h12);
        w(3'h0, 8'hFF);
        w(3'h1, PAL[0]);
        rc(3'h0, 8'hFF, "pointer mid word");
        for (int i = 1; i < 9; i++) begin
            w(3'h1, PAL[i]);
        end
        rc(3'h0, 8'h02, "pal wr wrap");
        w(3'h3, 8'hFF);
        rc(3'h0, 8'h00, "pal load prefetch");
        for (int i = 0; i < 6; i++) rc(3'h1, PAL[i], "pal data");
        rc(3'h0, 8'h02, "pal rd pointer");
        pix = 10'h1FF;
        repeat (3) @(negedge clk_sys_in);
        chk("display seg", color, {PAL[0], PAL[1], PAL[2]});
        w(3'h4, 8'h13);
        foreach (OVL[i]) w(3'h5, OVL[i]);
        rc(3'h0, 8'h15, "ovl wr pointer");
        w(3'h7, 8'h03);
        for (int i = 0; i < 3; i++) rc(3'h5, OVL[i], "ovl data");
        rc(3'h0, 8'h05, "ovl rd pointer");
        // Legacy: control byte ignored, six bits
        native = 1'b0;
        w(3'h0, 8'h10);
        foreach (LEG[i]) w(3'h1, LEG[i]);
        w(3'h3, 8'h10);
        for (int i = 0; i < 3; i++) rc(3'h1, {2'b00, LEG[i][5:0]}, "legacy data");
        pix = 10'h010;
        repeat (3) @(negedge clk_sys_in);
        chk("legacy color", color, {LEG[0][5:0], 2'b00, LEG[1][5:0], 2'b00,
            LEG[2][5:0], 2'b00});
        w(3'h0, 8'h00);
        w(3'h6, 8'h5A);
        chk("ctl no disturb", color, {LEG[0][5:0], 2'b00, LEG[1][5:0], 2'b00,
            LEG[2][5:0], 2'b00});
        // Second reset in mid-run
        resetn_in = 1'b0;
        repeat (3) @(negedge clk_sys_in);
        resetn_in = 1'b1;
        rc(3'h3, 8'h00, "pointer reset again");
        end_sim();
    end
endmodule

`default_nettype wire
